// [rtl/sgiad_defs.svh]
/*
 * Constants of the register guard and illegal access detector: bus widths,
 * register addresses, field positions, reset values and memory map bounds.
 * Assumes a 20-bit byte address space and an 8-bit data bus.
 */
`ifndef SGIAD_DEFS_SVH
`define SGIAD_DEFS_SVH

// ****************************************************************
// bus widths
// ****************************************************************
`define SGIAD_AW 20
`define SGIAD_DW 8

// ****************************************************************
// own registers
// ****************************************************************
`define SGIAD_CTRL_ADDR 20'hF0078
`define SGIAD_STAT_ADDR 20'hF0079
`define SGIAD_MASK_ADDR 20'hF007A
`define SGIAD_CTRL_RST 8'h00
`define SGIAD_CTRL_RW_MASK 8'hB7
`define SGIAD_BIT_DET_EN 7
`define SGIAD_BIT_RAMG_HI 5
`define SGIAD_BIT_RAMG_LO 4
`define SGIAD_BIT_PORT_G 2
`define SGIAD_BIT_IRQ_G 1
`define SGIAD_BIT_CLK_G 0
`define SGIAD_EV_W 2
`define SGIAD_EV_ILLEGAL 0
`define SGIAD_EV_BLOCKED 1
`define SGIAD_EV_RST 2'h0

// ****************************************************************
// memory map
// ****************************************************************
`define SGIAD_SFR1_LO 20'hFFF00
`define SGIAD_SFR1_HI 20'hFFFFF
`define SGIAD_SFR2_LO 20'hF0000
`define SGIAD_SFR2_HI 20'hF07FF
`define SGIAD_RSV_LO 20'h10000
`define SGIAD_RSV_HI 20'hEFFFF
`define SGIAD_FLASH_LO 20'h00000
`define SGIAD_FLASH_HI 20'h03FFF
`define SGIAD_RAM_LO 20'hFF900
`define SGIAD_RAM_HI 20'hFFEFF
`define SGIAD_RAMG_128 20'h00080
`define SGIAD_RAMG_256 20'h00100
`define SGIAD_RAMG_512 20'h00200

// ****************************************************************
// guarded register windows, plus the port output data window that is never guarded
// ****************************************************************
`define SGIAD_PORT_DATA_LO 20'hFFF00
`define SGIAD_PORT_DATA_HI 20'hFFF1F
`define SGIAD_PORT_DIR_LO 20'hFFF20
`define SGIAD_PORT_DIR_HI 20'hFFF2F
`define SGIAD_PULLUP_LO 20'hF0030
`define SGIAD_PULLUP_HI 20'hF0037
`define SGIAD_PORT_MODE 20'hF0060
`define SGIAD_ANALOG_CFG 20'hF0076
`define SGIAD_IRQ_LO 20'hFFFD0
`define SGIAD_IRQ_HI 20'hFFFEF
`define SGIAD_IRQ2_LO 20'hFFFE0
`define SGIAD_IRQ2_HI 20'hFFFEF
`define SGIAD_EDGE_LO 20'hF0038
`define SGIAD_EDGE_HI 20'hF0039
`define SGIAD_CLK_LO 20'hFFFA0
`define SGIAD_CLK_HI 20'hFFFA5
`define SGIAD_PERIPH_LO 20'hF00F0
`define SGIAD_PERIPH_HI 20'hF00F3
`define SGIAD_VDET_LO 20'hFFFA8
`define SGIAD_VDET_HI 20'hFFFA9
`define SGIAD_PARITY 20'hF00F5

`endif

// [rtl/sgiad_pkg.sv]
/*
 * Types shared by the guard and detector modules.
 * Assumes sgiad_defs.svh supplies the numeric constants.
 */
package sgiad_pkg;

	// register group a bus address belongs to
	typedef enum logic [1:0] {
		SGIAD_GRP_NONE,
		SGIAD_GRP_PORT,
		SGIAD_GRP_IRQ,
		SGIAD_GRP_CLK
	} sgiad_group_t;

	typedef logic [19:0] sgiad_addr_t;
	typedef logic [7:0] sgiad_data_t;

endpackage

// [rtl/sgiad_sfr_class.sv]
/*
 * Address classifier: sorts a bus address into the guarded register
 * group it belongs to, or none.
 * Assumes the address is stable while the access strobe is high.
 */
`timescale 1ns/1ps
`include "sgiad_defs.svh"

module sgiad_sfr_class (
	input wire sgiad_pkg::sgiad_addr_t i_addr, // bus address
	output sgiad_pkg::sgiad_group_t o_group // guarded group
);
	import sgiad_pkg::*;

	function automatic logic in_win(input sgiad_addr_t a, input sgiad_addr_t lo,
			input sgiad_addr_t hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		o_group = SGIAD_GRP_NONE;
		// port output data stays writable whatever the guard holds
		if (in_win(i_addr, `SGIAD_PORT_DATA_LO, `SGIAD_PORT_DATA_HI)) begin
			o_group = SGIAD_GRP_NONE;
		end else if (in_win(i_addr, `SGIAD_PORT_DIR_LO, `SGIAD_PORT_DIR_HI) ||
				in_win(i_addr, `SGIAD_PULLUP_LO, `SGIAD_PULLUP_HI) ||
				(i_addr == `SGIAD_PORT_MODE) ||
				(i_addr == `SGIAD_ANALOG_CFG)) begin
			o_group = SGIAD_GRP_PORT;
		end else if (in_win(i_addr, `SGIAD_IRQ_LO, `SGIAD_IRQ_HI) ||
				in_win(i_addr, `SGIAD_EDGE_LO, `SGIAD_EDGE_HI)) begin
			o_group = SGIAD_GRP_IRQ;
		end else if (in_win(i_addr, `SGIAD_CLK_LO, `SGIAD_CLK_HI) ||
				in_win(i_addr, `SGIAD_PERIPH_LO, `SGIAD_PERIPH_HI) ||
				in_win(i_addr, `SGIAD_VDET_LO, `SGIAD_VDET_HI) ||
				(i_addr == `SGIAD_PARITY)) begin
			o_group = SGIAD_GRP_CLK;
		end
	end

endmodule

// [rtl/sgiad_top.sv]
/*
 * Register write guard and illegal access detector on the internal bus.
 * Watches every fetch, read and write of the core, filters writes to
 * guarded register groups and the guarded low end of RAM, and requests a
 * reset on a prohibited access. Holds the guard control register plus an
 * event status and mask register driving one interrupt line.
 * Assumes the core issues at most one access per cycle, with the address
 * held beside a one-cycle strobe, and that the option level comes from
 * logic on the same clock.
 */
// Local design decision: the plain strobed port.
// Summary of operation
// - any reset clears guard control to zero
// - port guard blocks port control writes only
// - port output data writes always pass
// - interrupt guard blocks interrupt register writes
// - clock guard blocks clock, voltage, parity writes
// - active detection resets on prohibited access
// - detection enable bit switches detection
// - detection enable bit is set-only until reset
// - watchdog option forces detection on
// - fetch from top register block prohibited
// - fetch from second register block prohibited
// - read or fetch in reserved area 10000-EFFFF prohibited
// - read or fetch in flash allowed
// - any access in RAM allowed
// - RAM guard field protects 128/256/512 bytes
`timescale 1ns/1ps
`include "sgiad_defs.svh"

module sgiad_top (
	input wire logic i_core_clk, // system clock, 10 MHz
	input wire logic i_rst_n, // asynchronous reset, active low
	input wire sgiad_pkg::sgiad_addr_t i_bus_addr, // core access address
	input wire sgiad_pkg::sgiad_data_t i_bus_wdata, // core write data
	input wire logic i_bus_wr, // core write strobe
	input wire logic i_bus_rd, // core data read strobe
	input wire logic i_bus_fetch, // core instruction fetch strobe
	input wire logic i_watchdog_option_on, // option setting, level
	output sgiad_pkg::sgiad_data_t o_bus_rdata, // own register read data
	output logic o_wr_pass, // write forwarded to target
	output sgiad_pkg::sgiad_addr_t o_wr_addr, // forwarded write address
	output sgiad_pkg::sgiad_data_t o_wr_data, // forwarded write data
	output logic o_illegal_rst_req, // internal reset request pulse
	output logic o_detect_active, // detection in force
	output logic o_irq // interrupt, level
);
	import sgiad_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	logic det_en_q;
	logic ramg_hi_q;
	logic ramg_lo_q;
	logic port_g_q;
	logic irq_g_q;
	logic clk_g_q;
	logic wdt_on_q;
	logic wdt_taken_q;
	logic [`SGIAD_EV_W-1:0] stat_q;
	logic [`SGIAD_EV_W-1:0] stat_d;
	logic [`SGIAD_EV_W-1:0] mask_q;
	sgiad_data_t ctrl_rd;
	sgiad_data_t rdata_d;
	sgiad_group_t grp;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_mask;
	logic wr_blocked;
	logic illegal;
	logic detect;
	logic [`SGIAD_EV_W-1:0] ev;

	// ****************************************************************
	// helper functions
	// ****************************************************************
	function automatic logic in_range(input sgiad_addr_t a, input sgiad_addr_t lo,
			input sgiad_addr_t hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// prohibited-region compare for one access
	function automatic logic prohibited(input sgiad_addr_t a, input logic fetch,
			input logic rd);
		logic ng;
		ng = 1'b0;
		if (fetch && in_range(a, `SGIAD_SFR1_LO, `SGIAD_SFR1_HI)) begin
			ng = 1'b1;
		end
		if (fetch && in_range(a, `SGIAD_SFR2_LO, `SGIAD_SFR2_HI)) begin
			ng = 1'b1;
		end
		if ((fetch || rd) && in_range(a, `SGIAD_RSV_LO, `SGIAD_RSV_HI)) begin
			ng = 1'b1;
		end
		// flash and RAM ranges lie outside every window above
		prohibited = ng;
	endfunction

	// size of the guarded low end of RAM, zero when off
	function automatic sgiad_addr_t ram_guard_len(input logic hi, input logic lo);
		sgiad_addr_t len;
		len = '0;
		unique case ({hi, lo})
			2'b00: len = '0;
			2'b01: len = `SGIAD_RAMG_128;
			2'b10: len = `SGIAD_RAMG_256;
			2'b11: len = `SGIAD_RAMG_512;
		endcase
		ram_guard_len = len;
	endfunction

	// status-width field widened to the data bus
	function automatic sgiad_data_t ev_to_data(input logic [`SGIAD_EV_W-1:0] v);
		ev_to_data = {{(`SGIAD_DW-`SGIAD_EV_W){1'b0}}, v};
	endfunction

	// ****************************************************************
	// address decode
	// ****************************************************************
	sgiad_sfr_class u_class (
		.i_addr(i_bus_addr),
		.o_group(grp)
	);

	assign sel_ctrl = (i_bus_addr == `SGIAD_CTRL_ADDR);
	assign sel_stat = (i_bus_addr == `SGIAD_STAT_ADDR);
	assign sel_mask = (i_bus_addr == `SGIAD_MASK_ADDR);

	// ****************************************************************
	// write guard
	// ****************************************************************
	always_comb begin
		wr_blocked = 1'b0;
		unique case (grp)
			SGIAD_GRP_NONE: wr_blocked = 1'b0;
			SGIAD_GRP_PORT: wr_blocked = port_g_q;
			SGIAD_GRP_IRQ: wr_blocked = irq_g_q;
			SGIAD_GRP_CLK: wr_blocked = clk_g_q;
		endcase
		if (in_range(i_bus_addr, `SGIAD_RAM_LO, `SGIAD_RAM_HI) &&
				((i_bus_addr - `SGIAD_RAM_LO) < ram_guard_len(ramg_hi_q, ramg_lo_q))) begin
			wr_blocked = 1'b1;
		end
	end

	// blocked writes are dropped quietly: no flag of error on the bus
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wr_pass <= 1'b0;
		end else begin
			o_wr_pass <= i_bus_wr && !wr_blocked;
		end
	end

	// address and data copied every cycle, qualified by the pass pulse
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wr_addr <= '0;
			o_wr_data <= '0;
		end else begin
			o_wr_addr <= i_bus_addr;
			o_wr_data <= i_bus_wdata;
		end
	end

	// ****************************************************************
	// option capture
	// ****************************************************************
	// taken once after reset release; the option does not change at run time
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt_on_q <= 1'b0;
			wdt_taken_q <= 1'b0;
		end else if (!wdt_taken_q) begin
			wdt_on_q <= i_watchdog_option_on;
			wdt_taken_q <= 1'b1;
		end
	end

	// ****************************************************************
	// guard control register
	// ****************************************************************
	// detection enable: set-only until the next reset
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			det_en_q <= 1'(`SGIAD_CTRL_RST >> `SGIAD_BIT_DET_EN);
		end else if (i_bus_wr && sel_ctrl) begin
			det_en_q <= det_en_q | i_bus_wdata[`SGIAD_BIT_DET_EN];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ramg_hi_q <= 1'b0;
			ramg_lo_q <= 1'b0;
			port_g_q <= 1'b0;
			irq_g_q <= 1'b0;
			clk_g_q <= 1'b0;
		end else if (i_bus_wr && sel_ctrl) begin
			// whole-byte update of the guard fields; detection enable is set-only above
			ramg_hi_q <= i_bus_wdata[`SGIAD_BIT_RAMG_HI];
			ramg_lo_q <= i_bus_wdata[`SGIAD_BIT_RAMG_LO];
			port_g_q <= i_bus_wdata[`SGIAD_BIT_PORT_G];
			irq_g_q <= i_bus_wdata[`SGIAD_BIT_IRQ_G];
			clk_g_q <= i_bus_wdata[`SGIAD_BIT_CLK_G]; // software clears for programming
		end
	end

	// ****************************************************************
	// illegal access detection
	// ****************************************************************
	assign detect = det_en_q || wdt_on_q;
	assign illegal = detect && prohibited(i_bus_addr, i_bus_fetch, i_bus_rd);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_illegal_rst_req <= 1'b0;
		end else begin
			o_illegal_rst_req <= illegal;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_detect_active <= 1'b0;
		end else begin
			o_detect_active <= detect;
		end
	end

	// ****************************************************************
	// event status, mask and interrupt
	// ****************************************************************
	always_comb begin
		ev = '0;
		ev[`SGIAD_EV_ILLEGAL] = illegal;
		ev[`SGIAD_EV_BLOCKED] = i_bus_wr && wr_blocked;
		stat_d = stat_q;
		if (i_bus_wr && sel_stat) begin
			stat_d = stat_q & ~i_bus_wdata[`SGIAD_EV_W-1:0];
		end
		// a new event wins over a clear in the same cycle
		stat_d = stat_d | ev;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_q <= `SGIAD_EV_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_q <= `SGIAD_EV_RST;
		end else if (i_bus_wr && sel_mask) begin
			mask_q <= i_bus_wdata[`SGIAD_EV_W-1:0];
		end
	end

	// built from next status and mask so the level has no extra lag
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_d & (i_bus_wr && sel_mask ?
					i_bus_wdata[`SGIAD_EV_W-1:0] : mask_q));
		end
	end

	// ****************************************************************
	// register read port
	// ****************************************************************
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[`SGIAD_BIT_DET_EN] = det_en_q;
		ctrl_rd[`SGIAD_BIT_RAMG_HI] = ramg_hi_q;
		ctrl_rd[`SGIAD_BIT_RAMG_LO] = ramg_lo_q;
		ctrl_rd[`SGIAD_BIT_PORT_G] = port_g_q;
		ctrl_rd[`SGIAD_BIT_IRQ_G] = irq_g_q;
		ctrl_rd[`SGIAD_BIT_CLK_G] = clk_g_q;
		ctrl_rd = ctrl_rd & `SGIAD_CTRL_RW_MASK;
		rdata_d = '0;
		if (i_bus_rd) begin
			if (sel_ctrl) begin
				rdata_d = ctrl_rd;
			end else if (sel_stat) begin
				rdata_d = ev_to_data(stat_q);
			end else if (sel_mask) begin
				rdata_d = ev_to_data(mask_q);
			end
		end
	end

	// data stand one cycle after the read strobe, zero otherwise
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bus_rdata <= '0;
		end else begin
			o_bus_rdata <= rdata_d;
		end
	end

endmodule

// [sim/sgiad_core_model.sv]
/* Core bus master model: issues fetches, reads and writes, one per cycle.
   Assumes the shared clock; signals change only after rising edges. */
`timescale 1ns/1ps
module sgiad_core_model (
	input wire logic i_core_clk, // system clock
	output sgiad_pkg::sgiad_addr_t o_addr, // access address
	output sgiad_pkg::sgiad_data_t o_wdata, // write data
	output logic o_wr, // write strobe
	output logic o_rd, // read strobe
	output logic o_fetch // fetch strobe
);
	import sgiad_pkg::*;
	initial begin
		o_addr = 20'h00000;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_fetch = 1'b0;
	end
	// kind 0 write, 1 read, 2 fetch; writes are whole bytes
	// clock guard set and cleared by the bench: no programming session here
	task automatic acc(input int k, input sgiad_addr_t a, input sgiad_data_t d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= (k == 0);
		o_rd <= (k == 1);
		o_fetch <= (k == 2);
	endtask
	// released bus shows no stale values
	task automatic idle();
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_fetch <= 1'b0;
		o_addr <= ~o_addr;
		o_wdata <= ~o_wdata;
	endtask
endmodule

// [sim/sgiad_checker.sv]
/* Assertions on the ports of the guard and detector.
   Assumes it is bound into sgiad_top; one clock domain. */
`timescale 1ns/1ps
`include "sgiad_defs.svh"
module sgiad_checker (
	input wire logic i_core_clk, // clock
	input wire logic i_rst_n, // reset, active low
	input wire sgiad_pkg::sgiad_addr_t i_bus_addr, // address
	input wire sgiad_pkg::sgiad_data_t i_bus_wdata, // write data
	input wire logic i_bus_wr, // write strobe
	input wire logic i_bus_rd, // read strobe
	input wire logic i_bus_fetch, // fetch strobe
	input wire logic i_watchdog_option_on, // option level
	input wire sgiad_pkg::sgiad_data_t o_bus_rdata, // read data
	input wire logic o_wr_pass, // write forwarded
	input wire sgiad_pkg::sgiad_addr_t o_wr_addr, // forwarded address
	input wire sgiad_pkg::sgiad_data_t o_wr_data, // forwarded data
	input wire logic o_illegal_rst_req, // reset request
	input wire logic o_detect_active, // detection on
	input wire logic o_irq // interrupt
);
	import sgiad_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic acc = i_bus_rd | i_bus_fetch;
	// ****************************************************************
	// assertions
	// ****************************************************************
	sfr1_fetch_a: assert property (i_bus_fetch && o_detect_active
		&& i_bus_addr >= `SGIAD_SFR1_LO |=> o_illegal_rst_req) else $error("top fetch missed");
	sfr2_fetch_a: assert property (i_bus_fetch && o_detect_active
		&& i_bus_addr inside {[`SGIAD_SFR2_LO:`SGIAD_SFR2_HI]} |=> o_illegal_rst_req)
		else $error("second block fetch missed");
	rsv_access_a: assert property (acc && o_detect_active
		&& i_bus_addr inside {[`SGIAD_RSV_LO:`SGIAD_RSV_HI]} |=> o_illegal_rst_req)
		else $error("reserved access missed");
	flash_quiet_a: assert property (acc && i_bus_addr <= `SGIAD_FLASH_HI
		|=> !o_illegal_rst_req) else $error("flash access flagged");
	ram_quiet_a: assert property ((acc || i_bus_wr)
		&& i_bus_addr inside {[`SGIAD_RAM_LO:`SGIAD_RAM_HI]} |=> !o_illegal_rst_req)
		else $error("ram access flagged");
	detect_off_a: assert property (acc ##1 !o_detect_active |-> !o_illegal_rst_req)
		else $error("flag while detection off");
	detect_sticky_a: assert property (o_detect_active |=> o_detect_active)
		else $error("detection dropped");
	write_silent_a: assert property (i_bus_wr |=> !o_illegal_rst_req)
		else $error("write raised reset");
	port_data_a: assert property (i_bus_wr
		&& i_bus_addr inside {[`SGIAD_PORT_DATA_LO:`SGIAD_PORT_DATA_HI]}
		|=> o_wr_pass && o_wr_addr == $past(i_bus_addr)) else $error("port data write lost");
	cover property (i_bus_fetch ##1 o_illegal_rst_req);
	cover property (i_bus_wr ##1 !o_wr_pass);
	cover property ($rose(o_irq));
endmodule
bind sgiad_top sgiad_checker chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr),
	.i_bus_rd(i_bus_rd), .i_bus_fetch(i_bus_fetch), .i_watchdog_option_on(i_watchdog_option_on),
	.o_bus_rdata(o_bus_rdata), .o_wr_pass(o_wr_pass), .o_wr_addr(o_wr_addr),
	.o_wr_data(o_wr_data), .o_illegal_rst_req(o_illegal_rst_req),
	.o_detect_active(o_detect_active), .o_irq(o_irq));

// [sim/sgiad_top_test.sv]
/* Self-checking bench of the guard and detector: expected results queued
   per access, compared by a monitor. Assumes the core model drives the bus. */
`timescale 1ns/1ps
`include "sgiad_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module sgiad_top_test;
	import sgiad_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_watchdog_option_on = 1'b0;
	sgiad_addr_t i_bus_addr, o_wr_addr;
	sgiad_data_t i_bus_wdata, o_bus_rdata, o_wr_data;
	logic i_bus_wr, i_bus_rd, i_bus_fetch, o_wr_pass, o_illegal_rst_req, o_detect_active, o_irq;
	logic [37:0] q[$];
	logic [37:0] ev;
	logic seen = 1'b0;
	int n_errors = 0;
	int n_checks = 0;
	sgiad_addr_t ga[10] = '{`SGIAD_PORT_DIR_LO, `SGIAD_PULLUP_LO, `SGIAD_PORT_MODE,
		`SGIAD_ANALOG_CFG, `SGIAD_IRQ_LO, `SGIAD_EDGE_LO, `SGIAD_CLK_LO, `SGIAD_PERIPH_HI,
		`SGIAD_VDET_LO, `SGIAD_PARITY};
	sgiad_addr_t rl[4] = '{20'h00000, `SGIAD_RAMG_128, `SGIAD_RAMG_256, `SGIAD_RAMG_512};
	logic [22:0] tv[13] = '{{2'd2, 1'b1, `SGIAD_SFR1_LO}, {2'd2, 1'b1, `SGIAD_SFR1_HI},
		{2'd2, 1'b1, `SGIAD_SFR2_LO}, {2'd2, 1'b1, `SGIAD_SFR2_HI}, {2'd1, 1'b1, `SGIAD_RSV_LO},
		{2'd1, 1'b1, `SGIAD_RSV_HI}, {2'd2, 1'b1, `SGIAD_RSV_LO}, {2'd1, 1'b0, `SGIAD_FLASH_HI},
		{2'd2, 1'b0, `SGIAD_FLASH_LO}, {2'd1, 1'b0, `SGIAD_RAM_LO}, {2'd2, 1'b0, `SGIAD_RAM_HI},
		{2'd0, 1'b0, `SGIAD_RAM_HI}, {2'd0, 1'b0, `SGIAD_RSV_LO}};
	always #50 i_core_clk = ~i_core_clk;
	sgiad_core_model core_u (.i_core_clk(i_core_clk), .o_addr(i_bus_addr), .o_wdata(i_bus_wdata),
		.o_wr(i_bus_wr), .o_rd(i_bus_rd), .o_fetch(i_bus_fetch));
	sgiad_top dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_bus_addr(i_bus_addr),
		.i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
		.i_bus_fetch(i_bus_fetch), .i_watchdog_option_on(i_watchdog_option_on),
		.o_bus_rdata(o_bus_rdata), .o_wr_pass(o_wr_pass), .o_wr_addr(o_wr_addr),
		.o_wr_data(o_wr_data), .o_illegal_rst_req(o_illegal_rst_req),
		.o_detect_active(o_detect_active), .o_irq(o_irq));
	// ****************************************************************
	// monitor: one result per access, a cycle later
	// ****************************************************************
	always @(posedge i_core_clk) seen <= i_bus_wr | i_bus_rd | i_bus_fetch;
	always @(negedge i_core_clk) begin
		if (seen && q.size() > 0) begin
			ev = q.pop_front();
			`CHK({o_wr_pass, o_illegal_rst_req, o_bus_rdata, o_wr_data, o_wr_addr}, ev)
		end
	end
	task automatic op(input int k, input sgiad_addr_t a, input sgiad_data_t d, input logic p,
		input logic r, input sgiad_data_t e);
		q.push_back({p, r, e, d, a});
		core_u.acc(k, a, d);
	endtask
	task automatic wr(input sgiad_addr_t a, input sgiad_data_t d, input logic p);
		op(0, a, d, p, 1'b0, 8'h00);
	endtask
	task automatic rd(input sgiad_addr_t a, input sgiad_data_t e);
		op(1, a, 8'($urandom), 1'b0, 1'b0, e);
	endtask
	// level check: 0 interrupt, 1 detection active, 2 reset request
	task automatic lvl(input int s, input logic e);
		core_u.idle();
		core_u.idle();
		@(negedge i_core_clk);
		`CHK(s == 0 ? o_irq : (s == 1 ? o_detect_active : o_illegal_rst_req), e)
	endtask
	task automatic rst(input int n);
		core_u.idle();
		// let the last pending result be compared first
		core_u.idle();
		i_rst_n <= 1'b0;
		repeat (n) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_core_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		void'($urandom(61));
		rst(12);
		rd(`SGIAD_CTRL_ADDR, 8'h00);
		for (int b = 0; b < 3; b++) begin
			wr(`SGIAD_CTRL_ADDR, 8'(1 << b), 1'b1);
			wr(`SGIAD_PORT_DIR_HI, 8'($urandom), b != 2);
			wr(`SGIAD_IRQ2_LO, 8'($urandom), b != 1);
			wr(`SGIAD_VDET_HI, 8'($urandom), b != 0);
		end
		wr(`SGIAD_CTRL_ADDR, 8'h07, 1'b1);
		foreach (ga[i]) wr(ga[i], 8'($urandom), 1'b0);
		wr(`SGIAD_PORT_DATA_LO, 8'($urandom), 1'b1);
		wr(`SGIAD_PORT_DATA_HI, 8'($urandom), 1'b1);
		rd(`SGIAD_PORT_DIR_LO, 8'h00);
		wr(`SGIAD_MASK_ADDR, 8'h02, 1'b1);
		lvl(0, 1'b1);
		rd(`SGIAD_STAT_ADDR, 8'h02);
		wr(`SGIAD_STAT_ADDR, 8'h02, 1'b1);
		lvl(0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(`SGIAD_CTRL_ADDR, 8'(c << 4), 1'b1);
			wr(`SGIAD_RAM_LO + rl[c], 8'($urandom), 1'b1);
			if (c > 0) wr(`SGIAD_RAM_LO + rl[c] - 20'h1, 8'($urandom), 1'b0);
		end
		wr(`SGIAD_CTRL_ADDR, 8'h00, 1'b1);
		op(2, `SGIAD_SFR1_LO, 8'h5A, 1'b0, 1'b0, 8'h00);
		wr(`SGIAD_CTRL_ADDR, 8'h80, 1'b1);
		wr(`SGIAD_MASK_ADDR, 8'h01, 1'b1);
		foreach (tv[i]) op(int'(tv[i][22:21]), tv[i][19:0], 8'($urandom),
			tv[i][22:21] == 2'd0, tv[i][20], 8'h00);
		lvl(0, 1'b1);
		wr(`SGIAD_CTRL_ADDR, 8'hFF, 1'b1);
		rd(`SGIAD_CTRL_ADDR, `SGIAD_CTRL_RW_MASK);
		wr(`SGIAD_CTRL_ADDR, 8'h00, 1'b1);
		rd(`SGIAD_CTRL_ADDR, 8'h80);
		rst(2);
		lvl(1, 1'b0);
		rd(`SGIAD_CTRL_ADDR, 8'h00);
		i_watchdog_option_on <= 1'b1;
		rst(2);
		lvl(1, 1'b1);
		rd(`SGIAD_CTRL_ADDR, 8'h00);
		op(2, `SGIAD_SFR1_HI, 8'hA5, 1'b0, 1'b1, 8'h00);
		lvl(2, 1'b0);
		print_verdict();
	end
	initial begin
		repeat (2000) @(posedge i_core_clk);
		n_errors++;
		print_verdict();
	end
endmodule
